// >>> rtl/hot_plug_slot_control_config.sv
// Contract
// [RQ1] Config bits invert the five slot inputs.
// [RQ2] Config bits invert the four slot outputs.
// [RQ3] Open latch removes power when enabled, present.
// [RQ4] Latch input can report interlock state instead.
// [RQ5] Pulse mode: command gives 125 ms pulse.
// [RQ6] Toggle mode: command inverts interlock output.
// [RQ7] Two-bit field selects downstream reset source.
// [RQ8] Wait power-to-reset delay before reset negation.
// [RQ9] Wait reset-to-power delay before power removal.
// [RQ10] Scratch register, read/write, resets to zero.
// [RQ11] 10 ms timebase; delays latched at start.
// [RQ12] Delay start: power good or enable.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module hot_plug_slot_control_config #(
    parameter int TICK_CYCLES  = hp_slot_pkg::TICK_DEF,
    parameter int ILOCK_CYCLES = hp_slot_pkg::ILOCK_DEF
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        power_controller_control,
    input  wire logic        latch_present_cap,
    input  wire logic        interlock_command_bit,
    input  wire logic        attn_indicator_on,
    input  wire logic        power_indicator_on,
    input  wire logic        hot_reset_req,
    input  wire logic        attn_button_in,
    input  wire logic        presence_detect_in,
    input  wire logic        power_fault_in,
    input  wire logic        latch_sensor_in,
    input  wire logic        slot_power_good_in,
    output logic             attn_indicator_out,
    output logic             power_indicator_out,
    output logic             slot_power_enable_out,
    output logic             interlock_out,
    output logic             slot_reset_n_out,
    output logic             attn_button_pressed,
    output logic             presence_detected,
    output logic             power_fault_seen,
    output logic             latch_open,
    output logic             interlock_engaged,
    output logic             power_good
);
    // Pins are active low on the button, presence, fault, latch, good
    // inputs and the two indicators; a set config bit flips the sense.
    function automatic logic pol(input logic lvl, input logic inv);
        pol = lvl ^ inv;
    endfunction

    logic [31:0] cfg_r, cfg_nxt, scr_r, scr_nxt, rd_r, rd_nxt;
    logic        err_r, err_nxt, rdy_r;
    logic        setup, wr_acc, hit_cfg, hit_scr;

    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite;
    assign hit_cfg = paddr == hp_slot_pkg::ADDR_HPCFG;
    assign hit_scr = paddr == hp_slot_pkg::ADDR_SCRATCH;

    // Read data and error are prepared in the setup cycle, so the slave
    // answers in the first access cycle with no wait states.
    always_comb begin
        cfg_nxt = cfg_r;
        scr_nxt = scr_r;
        rd_nxt  = rd_r;
        err_nxt = err_r;
        if (setup) begin
            err_nxt = !(hit_cfg || hit_scr);
            rd_nxt  = hit_cfg ? cfg_r : (hit_scr ? scr_r : 32'h0000_0000);
        end
        if (wr_acc && hit_cfg) begin
            cfg_nxt = pwdata & hp_slot_pkg::CFG_WMASK;
        end
        if (wr_acc && hit_scr) begin
            scr_nxt = pwdata; // RQ10
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= hp_slot_pkg::CFG_RESET;
            scr_r <= hp_slot_pkg::SCRATCH_RESET;
            rd_r  <= 32'h0000_0000;
            err_r <= 1'b0;
            rdy_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            scr_r <= scr_nxt;
            rd_r  <= rd_nxt;
            err_r <= err_nxt;
            rdy_r <= 1'b1;
        end
    end

    assign prdata  = rd_r;
    assign pready  = rdy_r;
    assign pslverr = err_r;

    // Corrected input levels, active high.
    logic ab_c, pd_c, pf_c, lt_c, pg_c, lt_open, il_state;
    assign ab_c = pol(!attn_button_in,     cfg_r[hp_slot_pkg::B_INV_AB]);
    assign pd_c = pol(!presence_detect_in, cfg_r[hp_slot_pkg::B_INV_PD]);
    assign pf_c = pol(!power_fault_in,     cfg_r[hp_slot_pkg::B_INV_PF]);
    assign lt_c = pol(!latch_sensor_in,  cfg_r[hp_slot_pkg::B_INV_LATCH]);
    assign pg_c = pol(!slot_power_good_in, cfg_r[hp_slot_pkg::B_INV_PG]);
    assign lt_open  = lt_c && !cfg_r[hp_slot_pkg::B_LATCH_IL]; // RQ4
    assign il_state = lt_c && cfg_r[hp_slot_pkg::B_LATCH_IL]; // RQ4

    // Interlock drive.
    logic        il_lvl_r, il_lvl_nxt, il_pls_r, il_pls_nxt;
    logic [23:0] il_cnt_r, il_cnt_nxt;

    always_comb begin
        il_lvl_nxt = il_lvl_r;
        il_pls_nxt = il_pls_r;
        il_cnt_nxt = il_cnt_r;
        if (il_pls_r) begin
            if (il_cnt_r == 24'h00_0000) begin
                il_lvl_nxt = 1'b0;
                il_pls_nxt = 1'b0;
            end else begin
                il_cnt_nxt = il_cnt_r - 24'h00_0001;
            end
        end
        if (interlock_command_bit) begin
            if (cfg_r[hp_slot_pkg::B_TOGGLE]) begin
                il_lvl_nxt = !il_lvl_r; // RQ6
                il_pls_nxt = 1'b0;
            end else begin
                il_lvl_nxt = 1'b1; // RQ5
                il_pls_nxt = 1'b1;
                il_cnt_nxt = 24'(ILOCK_CYCLES - 1);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            il_lvl_r <= 1'b0;
            il_pls_r <= 1'b0;
            il_cnt_r <= 24'h00_0000;
        end else begin
            il_lvl_r <= il_lvl_nxt;
            il_pls_r <= il_pls_nxt;
            il_cnt_r <= il_cnt_nxt;
        end
    end

    // Power and reset sequencing.
    hp_slot_pkg::pwr_state_t st_r, st_nxt;
    hp_slot_pkg::rst_src_t   src;
    logic [7:0]  dly_r, dly_nxt;
    logic [20:0] tk_r, tk_nxt;
    logic        tick, kill, pwr_req, started, restart, rst_act;

    assign src  = hp_slot_pkg::rst_src_t'(cfg_r[hp_slot_pkg::RSTSRC_LO +: 2]);
    assign kill = cfg_r[hp_slot_pkg::B_AUTO_OFF] && latch_present_cap
                  && lt_open; // RQ3
    assign pwr_req = !power_controller_control && !kill; // RQ3
    // A lost power good holds the delay at its start value.
    assign started = (src == hp_slot_pkg::RST_PGC) ? pg_c : 1'b1; // RQ12
    assign tick    = tk_r == 21'(TICK_CYCLES - 1); // RQ11

    always_comb begin
        st_nxt  = st_r;
        dly_nxt = dly_r;
        restart = 1'b0;
        case (st_r)
            hp_slot_pkg::PWR_OFF: begin
                if (pwr_req) begin
                    st_nxt  = hp_slot_pkg::PWR_UP;
                    dly_nxt = cfg_r[hp_slot_pkg::P2R_LO +: 8]; // RQ11
                    restart = 1'b1;
                end
            end
            hp_slot_pkg::PWR_UP: begin
                if (!pwr_req) begin
                    st_nxt = hp_slot_pkg::PWR_OFF;
                end else if (!started) begin
                    dly_nxt = cfg_r[hp_slot_pkg::P2R_LO +: 8]; // RQ12
                    restart = 1'b1;
                end else if (dly_r == 8'h00) begin
                    st_nxt = hp_slot_pkg::PWR_RUN; // RQ8
                end else if (tick) begin
                    dly_nxt = dly_r - 8'h01; // RQ8
                end
            end
            hp_slot_pkg::PWR_RUN: begin
                if (!pwr_req) begin
                    st_nxt  = hp_slot_pkg::PWR_DOWN; // RQ9
                    dly_nxt = cfg_r[hp_slot_pkg::R2P_LO +: 8]; // RQ11
                    restart = 1'b1;
                end
            end
            hp_slot_pkg::PWR_DOWN: begin
                if (dly_r == 8'h00) begin
                    st_nxt = hp_slot_pkg::PWR_OFF; // RQ9
                end else if (tick) begin
                    dly_nxt = dly_r - 8'h01; // RQ9
                end
            end
            default: begin
                st_nxt = hp_slot_pkg::PWR_OFF;
            end
        endcase
        tk_nxt = (restart || tick) ? 21'h00_0000 : tk_r + 21'h00_0001;
    end

    // Reserved source value behaves as the power enable source.
    always_comb begin
        case (src)
            hp_slot_pkg::RST_HOT: rst_act = st_r != hp_slot_pkg::PWR_RUN
                                            || hot_reset_req; // RQ7
            default:              rst_act = st_r != hp_slot_pkg::PWR_RUN;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r  <= hp_slot_pkg::PWR_OFF;
            dly_r <= 8'h00;
            tk_r  <= 21'h00_0000;
        end else begin
            st_r  <= st_nxt;
            dly_r <= dly_nxt;
            tk_r  <= tk_nxt;
        end
    end

    // Pin and status outputs, all registered.
    logic [10:0] po_r, po_nxt;
    logic        pen;
    assign pen = st_r != hp_slot_pkg::PWR_OFF;

    always_comb begin
        po_nxt[0]  = pol(!attn_indicator_on,
                         cfg_r[hp_slot_pkg::B_INV_AI]); // RQ2
        po_nxt[1]  = pol(!power_indicator_on,
                         cfg_r[hp_slot_pkg::B_INV_PI]); // RQ2
        po_nxt[2]  = pol(pen, cfg_r[hp_slot_pkg::B_INV_PE]); // RQ2
        po_nxt[3]  = pol(il_lvl_r, cfg_r[hp_slot_pkg::B_INV_IL]); // RQ2
        po_nxt[4]  = !rst_act; // RQ7
        po_nxt[5]  = ab_c; // RQ1
        po_nxt[6]  = pd_c; // RQ1
        po_nxt[7]  = pf_c; // RQ1
        po_nxt[8]  = lt_open; // RQ4
        po_nxt[9]  = il_state; // RQ4
        po_nxt[10] = pg_c; // RQ1
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            po_r <= 11'h000;
        end else begin
            po_r <= po_nxt;
        end
    end

    assign attn_indicator_out    = po_r[0];
    assign power_indicator_out   = po_r[1];
    assign slot_power_enable_out = po_r[2];
    assign interlock_out         = po_r[3];
    assign slot_reset_n_out      = po_r[4];
    assign attn_button_pressed   = po_r[5];
    assign presence_detected     = po_r[6];
    assign power_fault_seen      = po_r[7];
    assign latch_open            = po_r[8];
    assign interlock_engaged     = po_r[9];
    assign power_good            = po_r[10];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_pg_inv;
        power_good == ($past(!slot_power_good_in)
                       ^ $past(cfg_r[hp_slot_pkg::B_INV_PG]));
    endproperty
    a_pg_inv: assert property (p_pg_inv) // RQ1
        else $error("power good sense wrong");

    property p_pe_out;
        (st_r == hp_slot_pkg::PWR_OFF && !cfg_r[hp_slot_pkg::B_INV_PE])
        |=> !slot_power_enable_out;
    endproperty
    a_pe_out: assert property (p_pe_out) // RQ2
        else $error("power enable driven while off");

    property p_auto_off;
        (st_r == hp_slot_pkg::PWR_RUN && kill)
        |=> st_r == hp_slot_pkg::PWR_DOWN ##1 !slot_reset_n_out;
    endproperty
    a_auto_off: assert property (p_auto_off) // RQ3
        else $error("open latch did not start power off");

    property p_latch_il;
        cfg_r[hp_slot_pkg::B_LATCH_IL] |=> !latch_open;
    endproperty
    a_latch_il: assert property (p_latch_il) // RQ4
        else $error("latch status shown in interlock mode");

    property p_pulse;
        (interlock_command_bit && !cfg_r[hp_slot_pkg::B_TOGGLE])
        |=> il_lvl_r [*8];
    endproperty
    a_pulse: assert property (p_pulse) // RQ5
        else $error("interlock pulse too short");

    property p_toggle;
        (interlock_command_bit && cfg_r[hp_slot_pkg::B_TOGGLE])
        |=> il_lvl_r != $past(il_lvl_r) && !il_pls_r;
    endproperty
    a_toggle: assert property (p_toggle) // RQ6
        else $error("interlock did not toggle");

    property p_p2r_done;
        (st_r == hp_slot_pkg::PWR_UP && pwr_req && started
         && dly_r == 8'h00) |=> st_r == hp_slot_pkg::PWR_RUN
        ##1 (slot_reset_n_out || src == hp_slot_pkg::RST_HOT);
    endproperty
    a_p2r_done: assert property (p_p2r_done) // RQ8
        else $error("reset not negated after delay");

    property p_r2p_hold;
        (st_r == hp_slot_pkg::PWR_DOWN && dly_r != 8'h00)
        |=> st_r == hp_slot_pkg::PWR_DOWN;
    endproperty
    a_r2p_hold: assert property (p_r2p_hold) // RQ9
        else $error("power removed before delay");

    property p_scratch;
        (wr_acc && hit_scr) |=> scr_r == $past(pwdata);
    endproperty
    a_scratch: assert property (p_scratch) // RQ10
        else $error("scratch write lost");

    property p_pgc_hold;
        (st_r == hp_slot_pkg::PWR_UP && pwr_req && !started)
        |=> dly_r == $past(cfg_r[hp_slot_pkg::P2R_LO +: 8]);
    endproperty
    a_pgc_hold: assert property (p_pgc_hold) // RQ12
        else $error("delay ran without power good");

    c_run: cover property (st_r == hp_slot_pkg::PWR_UP
                           ##1 st_r == hp_slot_pkg::PWR_RUN);
    c_off: cover property (st_r == hp_slot_pkg::PWR_DOWN
                           ##1 st_r == hp_slot_pkg::PWR_OFF);
    c_pulse: cover property (il_pls_r ##1 !il_pls_r);
    c_err: cover property (psel && penable && pslverr);
endmodule

// >>> rtl/hp_slot_pkg.sv
package hp_slot_pkg;
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] ADDR_HPCFG    = 12'h330;
    localparam logic [11:0] ADDR_SCRATCH  = 12'h334;
    localparam logic [31:0] CFG_RESET     = 32'h1414_0800;
    localparam logic [31:0] CFG_WMASK     = 32'hFFFF_F9FF;
    localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;
    localparam int B_INV_AB      = 0;
    localparam int B_INV_PD      = 1;
    localparam int B_INV_PF      = 2;
    localparam int B_INV_LATCH   = 3;
    localparam int B_INV_AI      = 4;
    localparam int B_INV_PI      = 5;
    localparam int B_INV_PE      = 6;
    localparam int B_INV_IL      = 7;
    localparam int B_INV_PG      = 8;
    localparam int B_AUTO_OFF    = 11;
    localparam int B_LATCH_IL    = 12;
    localparam int B_TOGGLE      = 13;
    localparam int RSTSRC_LO     = 14;
    localparam int P2R_LO        = 16;
    localparam int R2P_LO        = 24;
    localparam int CLK_HZ        = 125_000_000;
    localparam int TICK_MS       = 10;
    localparam int ILOCK_MS      = 125;
    localparam int TICK_DEF      = CLK_HZ / 1000 * TICK_MS;
    localparam int ILOCK_DEF     = CLK_HZ / 1000 * ILOCK_MS;
    typedef enum logic [1:0] {
        RST_PEC = 2'h0,
        RST_PGC = 2'h1,
        RST_HOT = 2'h2,
        RST_RSV = 2'h3
    } rst_src_t;
    typedef enum logic [1:0] {
        PWR_OFF  = 2'h0,
        PWR_UP   = 2'h1,
        PWR_RUN  = 2'h3,
        PWR_DOWN = 2'h2
    } pwr_state_t;
endpackage

// >>> bench/slot_hw_model.sv
`timescale 1ns/1ps
// Slot power supply and retention latch. Power good follows the enable
// after a programmable number of cycles and drops at once with it, so the
// bench can try both a prompt and a slow supply.
module slot_hw_model (
    input  wire logic       mclk,
    input  wire logic       slot_power_enable_out,
    input  wire logic       pe_inv,
    input  wire logic       pg_inv,
    input  wire logic       latch_inv,
    input  wire logic       latch_req,
    input  wire logic [2:0] pg_dly,
    output logic            slot_power_good_in,
    output logic            latch_sensor_in
);
    logic [2:0] cnt_r = 3'h0;
    logic       good;

    always @(posedge mclk) begin
        if (!(slot_power_enable_out ^ pe_inv)) begin
            cnt_r <= 3'h0;
        end else if (cnt_r != pg_dly) begin
            cnt_r <= cnt_r + 3'h1;
        end
    end
    assign good = (slot_power_enable_out ^ pe_inv) && (cnt_r == pg_dly);
    assign slot_power_good_in = ~good ^ pg_inv;
    assign latch_sensor_in = ~latch_req ^ latch_inv;
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
    localparam int T  = 4;
    localparam int IL = 16;
    logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, cfg, rdv;
    logic        power_controller_control, latch_present_cap;
    logic        interlock_command_bit, attn_indicator_on;
    logic        power_indicator_on, hot_reset_req, attn_button_in;
    logic        presence_detect_in, power_fault_in, latch_sensor_in;
    logic        slot_power_good_in, attn_indicator_out, interlock_out;
    logic        power_indicator_out, slot_power_enable_out;
    logic        slot_reset_n_out, attn_button_pressed, presence_detected;
    logic        power_fault_seen, latch_open, interlock_engaged;
    logic        power_good, latch_req, pe_on, il_on;
    logic [2:0]  pg_dly;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          seed, t0, d, r;

    assign pe_on = slot_power_enable_out ^ cfg[6];
    assign il_on = interlock_out ^ cfg[7];

    hot_plug_slot_control_config #(.TICK_CYCLES(T), .ILOCK_CYCLES(IL))
        u_hot_plug_slot_control_config (.mclk, .rst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .power_controller_control, .latch_present_cap,
        .interlock_command_bit, .attn_indicator_on, .power_indicator_on,
        .hot_reset_req, .attn_button_in, .presence_detect_in,
        .power_fault_in, .latch_sensor_in, .slot_power_good_in,
        .attn_indicator_out, .power_indicator_out, .slot_power_enable_out,
        .interlock_out, .slot_reset_n_out, .attn_button_pressed,
        .presence_detected, .power_fault_seen, .latch_open,
        .interlock_engaged, .power_good);
    slot_hw_model u_slot_hw_model (.mclk, .slot_power_enable_out,
        .pe_inv(cfg[6]), .pg_inv(cfg[8]), .latch_inv(cfg[3]), .latch_req,
        .pg_dly, .slot_power_good_in, .latch_sensor_in);

    always #4 mclk = ~mclk;
    // Counting on the falling edge keeps time stamps free of edge races.
    always @(negedge mclk) cyc <= cyc + 1;

    function automatic logic act_lo(input logic pin, input logic inv);
        return ~pin ^ inv;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] v);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdv = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] v,
                          input logic e);
        apb(1'b0, a, 32'h0);
        chk(rdv, v);
        chk_bit(rerr, e);
    endtask
    task automatic wr_cfg(input logic [31:0] v);
        apb(1'b1, hp_slot_pkg::ADDR_HPCFG, v);
        // The pins follow the new config one cycle after the write lands.
        @(posedge mclk);
        cfg <= v;
    endtask
    task automatic cmd_pulse;
        @(posedge mclk);
        interlock_command_bit <= 1'b1;
        @(posedge mclk);
        interlock_command_bit <= 1'b0;
    endtask

    task automatic stop_test;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        stop_test;
    end

    initial begin
        seed = 32'h532bb2c6;
        {mclk, rst_n, psel, penable, pwrite, interlock_command_bit} = 6'h00;
        {latch_present_cap, hot_reset_req, latch_req} = 3'h0;
        {attn_indicator_on, power_indicator_on} = 2'h0;
        {attn_button_in, presence_detect_in, power_fault_in} = 3'h7;
        power_controller_control = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pg_dly = 3'h3;
        cfg = 32'h1414_0800;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rd_chk(hp_slot_pkg::ADDR_HPCFG, 32'h1414_0800, 1'b0);
        rd_chk(hp_slot_pkg::ADDR_SCRATCH, 32'h0, 1'b0);
        r = $random(seed);
        apb(1'b1, hp_slot_pkg::ADDR_SCRATCH, r);
        rd_chk(hp_slot_pkg::ADDR_SCRATCH, r, 1'b0);
        apb(1'b1, 12'h338, 32'hFFFF_FFFF);
        rd_chk(12'h338, 32'h0, 1'b1);
        wr_cfg(32'hFFFF_FFFF);
        rd_chk(hp_slot_pkg::ADDR_HPCFG, 32'hFFFF_F9FF, 1'b0);
        repeat (8) begin
            wr_cfg(($random(seed) & 32'h0000_11FF) | 32'h1414_0000);
            @(posedge mclk);
            {attn_button_in, presence_detect_in} <= 2'($random(seed));
            {power_fault_in, latch_req} <= 2'($random(seed));
            {attn_indicator_on, power_indicator_on} <= 2'($random(seed));
            latch_present_cap <= 1'($random(seed));
            repeat (3) @(posedge mclk);
            #1;
            chk_bit(attn_button_pressed, act_lo(attn_button_in, cfg[0]));
            chk_bit(presence_detected, act_lo(presence_detect_in, cfg[1]));
            chk_bit(power_fault_seen, act_lo(power_fault_in, cfg[2]));
            chk_bit(power_good, act_lo(slot_power_good_in, cfg[8]));
            chk_bit(latch_open, !cfg[12] && latch_req);
            chk_bit(interlock_engaged, cfg[12] && latch_req);
            chk_bit(attn_indicator_out, ~attn_indicator_on ^ cfg[4]);
            chk_bit(power_indicator_out, ~power_indicator_on ^ cfg[5]);
            chk_bit(slot_power_enable_out, cfg[6]);
            chk_bit(interlock_out, cfg[7]);
        end
        {latch_req, latch_present_cap} <= 2'h0;
        for (int m = 0; m < 4; m++) begin
            d = (m == 0) ? 3 : {$random(seed)} % 4;
            r = {$random(seed)} % 4;
            pg_dly <= 3'($random(seed));
            hot_reset_req <= (m == 2);
            wr_cfg({r[7:0], d[7:0], m[1:0], 14'h0} | ($random(seed) & 9'h1FF));
            @(posedge mclk);
            power_controller_control <= 1'b0;
            wait (pe_on === 1'b1);
            t0 = cyc;
            // A delay written mid-sequence must not shorten the one running.
            if (m == 0) wr_cfg(cfg & 32'hFF00_FFFF);
            if (m == 1) begin
                wait (power_good === 1'b1);
                t0 = cyc;
            end
            if (m == 2) begin
                repeat (d * T + 12) @(posedge mclk);
                chk_bit(slot_reset_n_out, 1'b0);
                hot_reset_req <= 1'b0;
                t0 = cyc;
                d = 0;
            end
            wait (slot_reset_n_out === 1'b1);
            chk_cnt(cyc - t0, d * T, d * T + 4);
            @(posedge mclk);
            power_controller_control <= 1'b1;
            t0 = cyc;
            wait (pe_on === 1'b0);
            chk_cnt(cyc - t0, r * T, r * T + 5);
            chk_bit(slot_reset_n_out, 1'b0);
        end
        latch_present_cap <= 1'b1;
        wr_cfg(32'h0100_0800);
        power_controller_control <= 1'b0;
        wait (slot_reset_n_out === 1'b1);
        @(posedge mclk);
        latch_req <= 1'b1;
        t0 = cyc;
        wait (pe_on === 1'b0);
        chk_cnt(cyc - t0, 0, T + 6);
        power_controller_control <= 1'b1;
        wr_cfg(32'h1414_0800 | ($random(seed) & 32'h80));
        cmd_pulse;
        wait (il_on === 1'b1);
        t0 = cyc;
        wait (il_on === 1'b0);
        chk_cnt(cyc - t0, IL, IL);
        wr_cfg(cfg | 32'h2000);
        for (int k = 0; k < 2; k++) begin
            cmd_pulse;
            repeat (IL + 4) @(posedge mclk);
            chk_bit(il_on, k == 0);
        end
        stop_test;
    end
endmodule
